/* src/prs_consts.vh */
// Constants for the PLL readback status register block
`ifndef PRS_CONSTS_VH
`define PRS_CONSTS_VH

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define PRS_IDX_STATUS      8'h1f
`define PRS_IDX_IRQ_STAT    8'h20
`define PRS_IDX_IRQ_CLR     8'h21
`define PRS_IDX_IRQ_EN      8'h22

// ****************************************************************
// Status field positions
// ****************************************************************
`define PRS_BIT_LOCK              0
`define PRS_BIT_FIRST_REF_ABOVE   1
`define PRS_BIT_SECOND_REF_ABOVE  2
`define PRS_BIT_VCO_ABOVE         3
`define PRS_BIT_SECOND_REF_SEL    4
`define PRS_BIT_HOLDOVER          5
`define PRS_BIT_CAL_DONE          6

// ****************************************************************
// Widths and reset values
// ****************************************************************
`define PRS_STAT_W          7
`define PRS_RST_STATUS      7'h00
`define PRS_RST_IRQ_EN      7'h00
`define PRS_RST_IRQ_STAT    7'h00
`define PRS_RST_RDATA       32'h00000000
`define PRS_SYNC_STAGES     2

`endif

/* src/prs_sync_bits.v */
// Two-stage synchroniser for a vector of independent level inputs
`default_nettype none

module prs_sync_bits #(
  parameter WIDTH = 7
) (
  // Clock and reset
  input  wire             i_clk,
  input  wire             i_rst_n,
  // Asynchronous levels in, synchronised levels out
  input  wire [WIDTH-1:0] i_async,
  output wire [WIDTH-1:0] o_sync
);

  reg [WIDTH-1:0] meta_r;
  reg [WIDTH-1:0] sync_r;

  // ****************************************************************
  // Synchroniser stages
  // ****************************************************************
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      meta_r <= {WIDTH{1'b0}};
      sync_r <= {WIDTH{1'b0}};
    end else begin
      meta_r <= i_async;
      sync_r <= meta_r;
    end
  end

  assign o_sync = sync_r;

endmodule // prs_sync_bits

`default_nettype wire

/* src/prs_event_irq.v */
// Sticky event flags with clear, enable and one level interrupt
`default_nettype none

module prs_event_irq #(
  parameter WIDTH = 7
) (
  // Clock and reset
  input  wire             i_clk,
  input  wire             i_rst_n,
  // Synchronised status levels
  input  wire [WIDTH-1:0] i_level,
  // Software controls
  input  wire [WIDTH-1:0] i_clr,
  input  wire [WIDTH-1:0] i_en,
  // Flags and interrupt
  output wire [WIDTH-1:0] o_sticky,
  output wire             o_irq
);

  reg  [WIDTH-1:0] prev_r;
  reg  [WIDTH-1:0] sticky_r;
  reg  [WIDTH-1:0] sticky_nxt;
  wire [WIDTH-1:0] change;

  // ****************************************************************
  // Change detection on every status bit
  // ****************************************************************
  assign change = i_level ^ prev_r;

  // Set wins over a clear in the same cycle
  always @* begin
    sticky_nxt = (sticky_r & ~i_clr) | change;
  end

  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      prev_r   <= {WIDTH{1'b0}};
      sticky_r <= {WIDTH{1'b0}};
    end else begin
      prev_r   <= i_level;
      sticky_r <= sticky_nxt;
    end
  end

  assign o_sticky = sticky_r;
  assign o_irq    = |(sticky_r & i_en);

endmodule // prs_event_irq

`default_nettype wire

/* src/prs_pll_readback_status.v */
// PLL readback status register with APB slave and status interrupt
//
// Behaviour
// (R1) Bit 6 reads 0 while VCO calibration is unfinished and 1 once done.
// (R2) Bit 5 reads 1 only while the holdover state is truly active.
// (R3) Bit 4 reads 0 for the first or differential reference, 1 for second.
// (R4) Bit 3 reads 1 when the VCO frequency is above its threshold.
// (R5) Bit 2 reads 1 when the second reference is above its threshold.
// (R6) Bit 1 reads 1 when the first reference is above its threshold.
// (R7) Bit 0 reads 1 when digital lock detect reports the PLL locked.
// (R8) Writes to the status register do nothing; reads show live state.
`include "prs_consts.vh"
`default_nettype none

module prs_pll_readback_status #(
  parameter ADDR_W = 12,
  parameter DATA_W = 32
) (
  // Clock and reset
  input  wire              i_clk,
  input  wire              i_rst_n,
  // APB slave
  input  wire              i_psel,
  input  wire              i_penable,
  input  wire              i_pwrite,
  input  wire [ADDR_W-1:0] i_paddr,
  input  wire [DATA_W-1:0] i_pwdata,
  output wire              o_pready,
  output reg  [DATA_W-1:0] o_prdata,
  output reg               o_pslverr,
  // Status sources
  input  wire              i_lock_detect,
  input  wire              i_first_reference_input_above,
  input  wire              i_second_reference_input_above,
  input  wire              i_vco_above,
  input  wire              i_second_reference_input_selected,
  input  wire              i_holdover_active,
  input  wire              i_vco_cal_done,
  // Interrupt
  output wire              o_irq
);

  localparam SW = `PRS_STAT_W;

  // ****************************************************************
  // Bus state machine states (one-hot)
  // ****************************************************************
  localparam [1:0] ST_IDLE   = 2'b01;
  localparam [1:0] ST_ACCESS = 2'b10;

  // ****************************************************************
  // Declarations
  // ****************************************************************
  reg  [1:0]        state_r;
  reg  [1:0]        state_nxt;
  reg  [SW-1:0]     irq_en_r;
  reg  [SW-1:0]     irq_en_nxt;
  reg  [SW-1:0]     irq_clr;
  reg  [DATA_W-1:0] rdata_nxt;
  reg               err_nxt;
  reg               wr_err_r;
  wire [SW-1:0]     raw_status;
  wire [SW-1:0]     status;
  wire [SW-1:0]     sticky;
  wire              setup_phase;
  wire              access_phase;
  wire              wr_done;
  wire              hit_status;
  wire              hit_irq_stat;
  wire              hit_irq_clr;
  wire              hit_irq_en;
  wire              hit_any;

  // ****************************************************************
  // Address decode
  // ****************************************************************
  function addr_hit;
    input [ADDR_W-1:0] addr;
    input [7:0]        idx;
    begin
      addr_hit = (addr == {{(ADDR_W-10){1'b0}}, idx, 2'b00});
    end
  endfunction

  assign hit_status   = addr_hit(i_paddr, `PRS_IDX_STATUS);
  assign hit_irq_stat = addr_hit(i_paddr, `PRS_IDX_IRQ_STAT);
  assign hit_irq_clr  = addr_hit(i_paddr, `PRS_IDX_IRQ_CLR);
  assign hit_irq_en   = addr_hit(i_paddr, `PRS_IDX_IRQ_EN);
  assign hit_any      = hit_status | hit_irq_stat |
                        hit_irq_clr | hit_irq_en;

  // ****************************************************************
  // Status source assembly
  // ****************************************************************
  assign raw_status[`PRS_BIT_LOCK]       = i_lock_detect;       // [R7]
  assign raw_status[`PRS_BIT_FIRST_REF_ABOVE] =
         i_first_reference_input_above;                          // [R6]
  assign raw_status[`PRS_BIT_SECOND_REF_ABOVE] =
         i_second_reference_input_above;                         // [R5]
  assign raw_status[`PRS_BIT_VCO_ABOVE]  = i_vco_above;         // [R4]
  assign raw_status[`PRS_BIT_SECOND_REF_SEL] =
         i_second_reference_input_selected;                      // [R3]
  assign raw_status[`PRS_BIT_HOLDOVER]   = i_holdover_active;   // [R2]
  assign raw_status[`PRS_BIT_CAL_DONE]   = i_vco_cal_done;      // [R1]

  // ****************************************************************
  // Synchronise sources into this clock
  // ****************************************************************
  prs_sync_bits #(
    .WIDTH (SW)
  ) u_sync (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_async (raw_status),
    .o_sync  (status)
  );

  // ****************************************************************
  // Event flags and interrupt
  // ****************************************************************
  prs_event_irq #(
    .WIDTH (SW)
  ) u_irq (
    .i_clk    (i_clk),
    .i_rst_n  (i_rst_n),
    .i_level  (status),
    .i_clr    (irq_clr),
    .i_en     (irq_en_r),
    .o_sticky (sticky),
    .o_irq    (o_irq)
  );

  // ****************************************************************
  // Bus phases
  // ****************************************************************
  assign setup_phase  = i_psel & ~i_penable & state_r[0];
  assign access_phase = i_psel & i_penable & state_r[1];
  assign o_pready     = access_phase;
  assign wr_done      = access_phase & i_pwrite & ~wr_err_r;

  // ****************************************************************
  // Bus state machine
  // ****************************************************************
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (setup_phase) begin
          state_nxt = ST_ACCESS;
        end
      end
      ST_ACCESS: begin
        if (!i_psel || i_penable) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // ****************************************************************
  // Read data and error, captured in setup
  // ****************************************************************
  always @* begin
    rdata_nxt = `PRS_RST_RDATA;
    err_nxt   = 1'b0;
    if (setup_phase) begin
      if (!hit_any) begin
        err_nxt = 1'b1;
      end else if (!i_pwrite) begin
        if (hit_status) begin
          rdata_nxt[SW-1:0] = status;                         // [R8]
        end else if (hit_irq_stat) begin
          rdata_nxt[SW-1:0] = sticky;
        end else if (hit_irq_en) begin
          rdata_nxt[SW-1:0] = irq_en_r;
        end
      end
    end
  end

  // ****************************************************************
  // Writable controls
  // ****************************************************************
  always @* begin
    irq_en_nxt = irq_en_r;
    irq_clr    = {SW{1'b0}};
    if (wr_done && hit_irq_en) begin
      irq_en_nxt = i_pwdata[SW-1:0];
    end
    if (wr_done && hit_irq_clr) begin
      irq_clr = i_pwdata[SW-1:0];
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      state_r   <= ST_IDLE;
      irq_en_r  <= `PRS_RST_IRQ_EN;
      o_prdata  <= `PRS_RST_RDATA;
      o_pslverr <= 1'b0;
      wr_err_r  <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      irq_en_r <= irq_en_nxt;
      if (setup_phase) begin
        o_prdata  <= rdata_nxt;
        o_pslverr <= err_nxt;
        wr_err_r  <= err_nxt;
      end else if (access_phase) begin
        o_prdata  <= `PRS_RST_RDATA;
        o_pslverr <= 1'b0;
        wr_err_r  <= 1'b0;
      end
    end
  end

endmodule // prs_pll_readback_status

`default_nettype wire

/* verif/prs_pll_readback_status_assertions.sv */
// Checker for the PLL readback status register block
`default_nettype none

module prs_pll_readback_status_assertions #(
  parameter ADDR_W = 12,
  parameter DATA_W = 32
) (
  // Clock, reset and bus
  input wire logic              i_clk,
  input wire logic              i_rst_n,
  input wire logic              i_psel,
  input wire logic              i_penable,
  input wire logic              i_pwrite,
  input wire logic [ADDR_W-1:0] i_paddr,
  input wire logic [DATA_W-1:0] i_pwdata,
  input wire logic              o_pready,
  input wire logic [DATA_W-1:0] o_prdata,
  input wire logic              o_pslverr,
  // Status sources and interrupt
  input wire logic              i_lock_detect,
  input wire logic              i_first_reference_input_above,
  input wire logic              i_second_reference_input_above,
  input wire logic              i_vco_above,
  input wire logic              i_second_reference_input_selected,
  input wire logic              i_holdover_active,
  input wire logic              i_vco_cal_done,
  input wire logic              o_irq
);
  logic [6:0] stat_w;
  logic [6:0] stat_q_r;
  logic [2:0] stab_r;
  logic       rd_stat;
  logic       wr_stat;
  assign stat_w = {i_vco_cal_done, i_holdover_active,
                   i_second_reference_input_selected, i_vco_above,
                   i_second_reference_input_above,
                   i_first_reference_input_above, i_lock_detect};
  // Cycles the status inputs have held still
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      stat_q_r <= 7'h00;
      stab_r   <= 3'h0;
    end else begin
      stat_q_r <= stat_w;
      stab_r   <= (stat_w != stat_q_r) ? 3'h0 :
                  (stab_r == 3'h7) ? 3'h7 : stab_r + 3'h1;
    end
  end
  assign rd_stat = i_psel && i_penable && !i_pwrite &&
                   (i_paddr == 12'h07c) && (stab_r >= 3'h5);
  assign wr_stat = i_psel && i_penable && i_pwrite && (i_paddr == 12'h07c);

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  property p_bit(int b, logic v);
    rd_stat |-> o_pready && (o_prdata[b] == v);
  endproperty

  AST_CAL_DONE: assert property (p_bit(6, i_vco_cal_done))
    else $error("bit 6 wrong");
  AST_HOLDOVER: assert property (p_bit(5, i_holdover_active))
    else $error("bit 5 wrong");
  AST_REF_SEL: assert property (
    p_bit(4, i_second_reference_input_selected)) else $error("bit 4 wrong");
  AST_VCO_ABOVE: assert property (p_bit(3, i_vco_above))
    else $error("bit 3 wrong");
  AST_SECOND_REF_ABOVE: assert property (
    p_bit(2, i_second_reference_input_above)) else $error("bit 2 wrong");
  AST_FIRST_REF_ABOVE: assert property (
    p_bit(1, i_first_reference_input_above)) else $error("bit 1 wrong");
  AST_LOCK: assert property (p_bit(0, i_lock_detect))
    else $error("bit 0 wrong");
  AST_UPPER_ZERO: assert property (
    rd_stat |-> o_prdata[31:7] == 25'h0) else $error("upper bits set");
  AST_WR_IGNORED: assert property (
    wr_stat |-> o_pready && !o_pslverr) else $error("status write refused");

  cover property (rd_stat && i_vco_cal_done);
  cover property (wr_stat);
  cover property (o_irq);
endmodule // prs_pll_readback_status_assertions
`default_nettype wire

/* verif/prs_pll_readback_status_tb.sv */
// Testbench for the PLL readback status register block
`default_nettype none

module prs_pll_readback_status_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [6:0]  stat;
  int          n_errors = 0;
  int          checks = 0;

  prs_pll_readback_status dut (
    .i_clk(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_pready(pready), .o_prdata(prdata), .o_pslverr(pslverr),
    .i_lock_detect(stat[0]), .i_first_reference_input_above(stat[1]),
    .i_second_reference_input_above(stat[2]), .i_vco_above(stat[3]),
    .i_second_reference_input_selected(stat[4]),
    .i_holdover_active(stat[5]), .i_vco_cal_done(stat[6]), .o_irq(irq));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // One APB transfer with read data and error compare
  task automatic acc(input logic w, input logic [11:0] a,
                     input logic [31:0] wd, input logic [31:0] exp,
                     input logic experr);
    @(posedge clk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= wd; penable <= 1'b0;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    if (!w) chk(prdata, exp);
    chk({31'h0, pslverr}, {31'h0, experr});
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic set_stat(input logic [6:0] v);
    @(posedge clk);
    stat <= v;
    repeat (6) @(posedge clk);
  endtask

  initial begin
    #100000;
    n_errors++;
    end_sim();
  end

  initial begin
    int i;
    psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    stat = 0; rst_n = 0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    acc(0, 12'h088, 0, 0, 0);
    acc(0, 12'h084, 0, 0, 0);
    for (i = 0; i < 7; i++) begin
      set_stat(7'h01 << i);
      acc(0, 12'h07c, 0, 32'h1 << i, 0);
    end
    set_stat(7'h55);
    acc(1, 12'h07c, 32'hffffffff, 0, 0);
    acc(0, 12'h07c, 0, 32'h55, 0);
    acc(0, 12'h100, 0, 0, 1);
    acc(1, 12'h084, 32'h7f, 0, 0);
    acc(0, 12'h080, 0, 0, 0);
    acc(1, 12'h088, 32'h20, 0, 0);
    acc(0, 12'h088, 0, 32'h20, 0);
    chk({31'h0, irq}, 0);
    set_stat(7'h75);
    chk({31'h0, irq}, 1);
    set_stat(7'h7d);
    acc(1, 12'h084, 32'h20, 0, 0);
    acc(0, 12'h080, 0, 32'h08, 0);
    chk({31'h0, irq}, 0);
    set_stat(7'h5d);
    chk({31'h0, irq}, 1);
    acc(1, 12'h084, 32'h7f, 0, 0);
    @(posedge clk);
    chk({31'h0, irq}, 0);
    end_sim();
  end
endmodule // prs_pll_readback_status_tb

bind prs_pll_readback_status prs_pll_readback_status_assertions #(
  .ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_chk (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_psel(i_psel),
  .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
  .i_pwdata(i_pwdata), .o_pready(o_pready), .o_prdata(o_prdata),
  .o_pslverr(o_pslverr), .i_lock_detect(i_lock_detect),
  .i_first_reference_input_above(i_first_reference_input_above),
  .i_second_reference_input_above(i_second_reference_input_above),
  .i_vco_above(i_vco_above),
  .i_second_reference_input_selected(i_second_reference_input_selected),
  .i_holdover_active(i_holdover_active),
  .i_vco_cal_done(i_vco_cal_done), .o_irq(o_irq));
`default_nettype wire
